// File: pbw_bridge_cfg.sv
// bridge bus numbers, secondary latency timer, i/o window decode and secondary status
`timescale 1ns/1ns
module pbw_bridge_cfg
  import pbw_pkg::*;
(
  input  wire logic        clk,
  input  wire logic        nrst,
  // configuration access from the primary bus
  input  wire logic        cfg_wr,
  input  wire logic        cfg_rd,
  input  wire logic [5:0]  cfg_dword,
  input  wire logic [3:0]  cfg_be,
  input  wire logic [31:0] cfg_wdata,
  output logic      [31:0] cfg_rdata,
  // type 1 configuration cycle seen on the primary bus
  input  wire logic        fwd_req,
  input  wire logic [7:0]  fwd_bus,
  output logic             fwd_claim,
  output logic             fwd_as_type0,
  output logic             fwd_as_type1,
  // i/o transaction address check
  input  wire logic        io_req,
  input  wire logic [31:0] io_addr,
  output logic             io_forward,
  output logic             io_done,
  // secondary initiator events from the bridge master logic
  input  wire logic        sec_frame_start,
  input  wire logic        sec_txn_end,
  output logic             sec_terminate,
  output logic             sec_grant_internal,
  // secondary bus pins, outside this clock domain
  input  wire logic        secondary_clk,
  input  wire logic        secondary_other_req_n,
  input  wire logic        secondary_system_error_n,
  input  wire logic        secondary_parity_error_n,
  // secondary condition events from the bridge's own logic
  input  wire logic        ev_parity_detect,
  input  wire logic        ev_master_abort,
  input  wire logic        ev_target_abort_rcvd,
  input  wire logic        ev_target_abort_sig,
  input  wire logic        bridge_is_master,
  input  wire logic        parity_response_en
);
  import pbw_pkg::*;

  logic        rst_meta_ff;
  logic        rst_n_ff;
  logic [7:0]  upstream_bus_ff;
  logic [7:0]  downstream_bus_ff;
  logic [7:0]  highest_bus_ff;
  logic [7:0]  latency_limit_ff;
  logic [3:0]  io_bottom_nib_ff;
  logic [3:0]  io_top_nib_ff;
  logic [15:0] io_bottom_up_ff;
  logic [15:0] io_top_up_ff;
  logic [15:0] flags_ff;
  logic [15:0] nxt_flags;
  logic [15:0] flag_set;
  logic [15:0] flag_clr;
  logic [31:0] nxt_rdata;
  logic [31:0] io_bottom_addr;
  logic [31:0] io_top_addr;
  logic [7:0]  lat_count_ff;
  logic        sclk_prev_ff;
  logic        sclk_rise;
  logic        in_range;
  pbw_lat_state_t lat_state_ff;
  logic [3:0]  pins_sync;

  // reset released through two flops; assertion stays asynchronous
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      rst_meta_ff <= 1'b0;
      rst_n_ff    <= 1'b0;
    end else begin
      rst_meta_ff <= 1'b1;
      rst_n_ff    <= rst_meta_ff;
    end
  end

  // secondary pins cross into clk before any logic looks at them
  pbw_sync #(
    .WIDTH   (4),
    .RST_VAL (4'he)
  ) u_pin_sync (
    .clk      (clk),
    .rst_n    (rst_n_ff),
    .async_in ({secondary_parity_error_n, secondary_system_error_n,
                secondary_other_req_n, secondary_clk}),
    .sync_out (pins_sync)
  );

  // secondary clock edge finder gives the pci-cycle enable
  always_ff @(posedge clk or negedge rst_n_ff) begin
    if (!rst_n_ff) begin
      sclk_prev_ff <= 1'b0;
    end else begin
      sclk_prev_ff <= pins_sync[0];
    end
  end
  assign sclk_rise = pins_sync[0] & ~sclk_prev_ff;

  // bus number and latency registers, byte-lane writes
  always_ff @(posedge clk or negedge rst_n_ff) begin
    if (!rst_n_ff) begin
      upstream_bus_ff   <= PBW_RST_BUS;
      downstream_bus_ff <= PBW_RST_BUS;
      highest_bus_ff    <= PBW_RST_BUS;
      latency_limit_ff  <= PBW_RST_LATENCY;
    end else if (cfg_wr && cfg_dword == PBW_DW_BUSNUM) begin
      if (cfg_be[0]) upstream_bus_ff   <= cfg_wdata[7:0];
      if (cfg_be[1]) downstream_bus_ff <= cfg_wdata[15:8];
      if (cfg_be[2]) highest_bus_ff    <= cfg_wdata[23:16];
      if (cfg_be[3]) latency_limit_ff  <= cfg_wdata[31:24];
    end
  end

  // i/o window registers; only upper nibbles of the low bytes are writable
  always_ff @(posedge clk or negedge rst_n_ff) begin
    if (!rst_n_ff) begin
      io_bottom_nib_ff <= PBW_RST_IO_NIB;
      io_top_nib_ff    <= PBW_RST_IO_NIB;
      io_bottom_up_ff  <= PBW_RST_IO_UPPER;
      io_top_up_ff     <= PBW_RST_IO_UPPER;
    end else if (cfg_wr) begin
      if (cfg_dword == PBW_DW_IOSTAT) begin
        if (cfg_be[0]) io_bottom_nib_ff <= cfg_wdata[7:4];
        if (cfg_be[1]) io_top_nib_ff    <= cfg_wdata[15:12];
      end
      if (cfg_dword == PBW_DW_IOUPPER) begin
        if (cfg_be[0]) io_bottom_up_ff[7:0]  <= cfg_wdata[7:0];
        if (cfg_be[1]) io_bottom_up_ff[15:8] <= cfg_wdata[15:8];
        if (cfg_be[2]) io_top_up_ff[7:0]     <= cfg_wdata[23:16];
        if (cfg_be[3]) io_top_up_ff[15:8]    <= cfg_wdata[31:24];
      end
    end
  end

  assign flag_clr = (cfg_wr && cfg_dword == PBW_DW_IOSTAT)
                  ? ({cfg_be[3] ? cfg_wdata[31:24] : 8'h00,
                      cfg_be[2] ? cfg_wdata[23:16] : 8'h00} & PBW_ST_W1C_MASK)
                  : 16'h0000;

  // status event sources; pins are active low after the synchroniser
  always_comb begin
    flag_set = 16'h0000;
    flag_set[PBW_ST_PARITY_DET] = ev_parity_detect;
    flag_set[PBW_ST_SYSERR_RCV] = ~pins_sync[2];
    flag_set[PBW_ST_MABORT_RCV] = ev_master_abort;
    flag_set[PBW_ST_TABORT_RCV] = ev_target_abort_rcvd;
    flag_set[PBW_ST_TABORT_SIG] = ev_target_abort_sig;
    flag_set[PBW_ST_DATA_PERR]  = ~pins_sync[3] & bridge_is_master & parity_response_en;
  end

  // set wins over a clear in the same cycle, so no event is lost
  assign nxt_flags = ((flags_ff & ~flag_clr) | flag_set) & PBW_ST_W1C_MASK;

  always_ff @(posedge clk or negedge rst_n_ff) begin
    if (!rst_n_ff) begin
      flags_ff <= PBW_RST_FLAGS;
    end else begin
      flags_ff <= nxt_flags | PBW_ST_FIXED;
    end
  end

  // read mux; low nibbles fixed at 0001b
  always_comb begin
    unique case (cfg_dword)
      PBW_DW_BUSNUM:  nxt_rdata = {latency_limit_ff, highest_bus_ff,
                                   downstream_bus_ff, upstream_bus_ff};
      PBW_DW_IOSTAT:  nxt_rdata = {flags_ff, io_top_nib_ff, PBW_IO_CAP_32,
                                   io_bottom_nib_ff, PBW_IO_CAP_32};
      PBW_DW_IOUPPER: nxt_rdata = {io_top_up_ff, io_bottom_up_ff};
      default:        nxt_rdata = 32'h0000_0000;
    endcase
  end

  // read data held until the next read
  always_ff @(posedge clk or negedge rst_n_ff) begin
    if (!rst_n_ff) begin
      cfg_rdata <= 32'h0000_0000;
    end else if (cfg_rd) begin
      cfg_rdata <= nxt_rdata;
    end
  end

  // inclusive bus range; software keeps highest bus correct
  assign in_range = (fwd_bus >= downstream_bus_ff) && (fwd_bus <= highest_bus_ff);

  // forwarding decision registered on each request
  always_ff @(posedge clk or negedge rst_n_ff) begin
    if (!rst_n_ff) begin
      fwd_claim    <= 1'b0;
      fwd_as_type0 <= 1'b0;
      fwd_as_type1 <= 1'b0;
    end else begin
      fwd_claim    <= fwd_req & in_range;
      fwd_as_type0 <= fwd_req & in_range & (fwd_bus == downstream_bus_ff);
      fwd_as_type1 <= fwd_req & in_range & (fwd_bus != downstream_bus_ff);
    end
  end

  assign io_bottom_addr = {io_bottom_up_ff, io_bottom_nib_ff, PBW_IO_BOT_FILL};
  assign io_top_addr    = {io_top_up_ff, io_top_nib_ff, PBW_IO_TOP_FILL};

  always_ff @(posedge clk or negedge rst_n_ff) begin
    if (!rst_n_ff) begin
      io_forward <= 1'b0;
      io_done    <= 1'b0;
    end else begin
      io_forward <= io_req & (io_addr >= io_bottom_addr) & (io_addr <= io_top_addr);
      io_done    <= io_req;
    end
  end

  // grant drops while another master requests
  assign sec_grant_internal = pins_sync[1];

  // latency timer counts pci cycles while the bridge owns the bus
  always_ff @(posedge clk or negedge rst_n_ff) begin
    if (!rst_n_ff) begin
      lat_state_ff <= PBW_LT_IDLE;
      lat_count_ff <= 8'h00;
    end else if (sec_frame_start) begin
      lat_state_ff <= PBW_LT_RUN;
      lat_count_ff <= 8'h00;
    end else if (sec_txn_end) begin
      lat_state_ff <= PBW_LT_IDLE;
    end else begin
      unique case (lat_state_ff)
        PBW_LT_IDLE: begin
          lat_state_ff <= PBW_LT_IDLE;
        end
        PBW_LT_RUN: begin
          if (lat_count_ff >= latency_limit_ff) begin
            lat_state_ff <= PBW_LT_EXPIRED;
          end else if (sclk_rise) begin
            lat_count_ff <= lat_count_ff + 8'h01;
          end
        end
        PBW_LT_EXPIRED: begin
          lat_state_ff <= PBW_LT_EXPIRED;
        end
        default: begin
          lat_state_ff <= PBW_LT_IDLE;
        end
      endcase
    end
  end

  // terminate after expiry once grant is gone
  always_ff @(posedge clk or negedge rst_n_ff) begin
    if (!rst_n_ff) begin
      sec_terminate <= 1'b0;
    end else begin
      // a new frame restarts the count, so a stale expiry must not leak into it
      sec_terminate <= (lat_state_ff == PBW_LT_EXPIRED) & ~pins_sync[1]
                     & ~sec_txn_end & ~sec_frame_start;
    end
  end

endmodule // pbw_bridge_cfg

// File: pbw_bridge_cfg_checker.sv
// port assertions for the bridge configuration block
`timescale 1ns/1ns
module pbw_bridge_cfg_checker
  import pbw_pkg::*;
(
  input wire logic        clk,
  input wire logic        nrst,
  input wire logic        cfg_rd,
  input wire logic [5:0]  cfg_dword,
  input wire logic [31:0] cfg_rdata,
  input wire logic        fwd_req,
  input wire logic        fwd_claim,
  input wire logic        fwd_as_type0,
  input wire logic        fwd_as_type1,
  input wire logic        io_req,
  input wire logic        io_done,
  input wire logic        sec_frame_start,
  input wire logic        sec_txn_end,
  input wire logic        sec_terminate,
  input wire logic        sec_grant_internal,
  input wire logic        secondary_other_req_n
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (!nrst);
  // six samples cover both synchroniser stages with margin
  sequence s_req_low;
    !secondary_other_req_n [*6];
  endsequence
  sequence s_req_high;
    secondary_other_req_n [*6];
  endsequence
  a_claim_cause: assert property (fwd_claim |-> $past(fwd_req))
    else $error("claim without a request");
  a_type_split: assert property (fwd_claim |-> fwd_as_type0 ^ fwd_as_type1)
    else $error("claimed cycle not exactly one type");
  a_io_answer: assert property (io_req |=> io_done)
    else $error("io check not answered");
  a_fixed_bits: assert property (cfg_rd && cfg_dword == PBW_DW_IOSTAT |=>
    cfg_rdata[3:0] == 4'h1 && cfg_rdata[11:8] == 4'h1 &&
    cfg_rdata[26:25] == 2'b01 && cfg_rdata[23:16] == 8'h00)
    else $error("fixed window or status bits wrong");
  a_grant_drop: assert property (s_req_low |-> !sec_grant_internal)
    else $error("grant kept while another master asks");
  a_grant_back: assert property (s_req_high |-> sec_grant_internal)
    else $error("grant missing with bus free");
  a_term_cause: assert property ($rose(sec_terminate) |-> !$past(sec_grant_internal))
    else $error("terminate while still granted");
  a_term_end: assert property (sec_txn_end |=> !sec_terminate)
    else $error("terminate outlives the transaction");
  a_start_clear: assert property (sec_frame_start |=> !sec_terminate)
    else $error("terminate right after frame start");
endmodule // pbw_bridge_cfg_checker

bind pbw_bridge_cfg pbw_bridge_cfg_checker i_pbw_bridge_cfg_checker (
  .clk(clk), .nrst(nrst), .cfg_rd(cfg_rd), .cfg_dword(cfg_dword), .cfg_rdata(cfg_rdata),
  .fwd_req(fwd_req), .fwd_claim(fwd_claim), .fwd_as_type0(fwd_as_type0),
  .fwd_as_type1(fwd_as_type1), .io_req(io_req), .io_done(io_done),
  .sec_frame_start(sec_frame_start), .sec_txn_end(sec_txn_end),
  .sec_terminate(sec_terminate), .sec_grant_internal(sec_grant_internal),
  .secondary_other_req_n(secondary_other_req_n));

// File: pbw_bridge_cfg_tb.sv
// self-checking bench for the bridge configuration block
`timescale 1ns/1ns
module pbw_bridge_cfg_tb;
  import pbw_pkg::*;
  logic        clk = 1'b0, nrst, cfg_wr, cfg_rd, fwd_req, io_req, sec_frame_start, sec_txn_end;
  logic        ev_parity_detect, ev_master_abort, ev_target_abort_rcvd, ev_target_abort_sig;
  logic        bridge_is_master, parity_response_en, run_clk, want_bus, raise_serr, raise_perr;
  logic [5:0]  cfg_dword;
  logic [3:0]  cfg_be;
  logic [7:0]  fwd_bus;
  logic [31:0] cfg_wdata, io_addr, cfg_rdata;
  logic        fwd_claim, fwd_as_type0, fwd_as_type1, io_forward, io_done;
  logic        sec_terminate, sec_grant_internal, secondary_clk, secondary_other_req_n;
  logic        secondary_system_error_n, secondary_parity_error_n;
  int          fail_count = 0, checks = 0, cyc = 0;

  pbw_bridge_cfg i_pbw_bridge_cfg (.clk(clk), .nrst(nrst), .cfg_wr(cfg_wr), .cfg_rd(cfg_rd),
    .cfg_dword(cfg_dword), .cfg_be(cfg_be), .cfg_wdata(cfg_wdata), .cfg_rdata(cfg_rdata),
    .fwd_req(fwd_req), .fwd_bus(fwd_bus), .fwd_claim(fwd_claim), .fwd_as_type0(fwd_as_type0),
    .fwd_as_type1(fwd_as_type1), .io_req(io_req), .io_addr(io_addr), .io_forward(io_forward),
    .io_done(io_done), .sec_frame_start(sec_frame_start), .sec_txn_end(sec_txn_end),
    .sec_terminate(sec_terminate), .sec_grant_internal(sec_grant_internal),
    .secondary_clk(secondary_clk), .secondary_other_req_n(secondary_other_req_n),
    .secondary_system_error_n(secondary_system_error_n),
    .secondary_parity_error_n(secondary_parity_error_n), .ev_parity_detect(ev_parity_detect),
    .ev_master_abort(ev_master_abort), .ev_target_abort_rcvd(ev_target_abort_rcvd),
    .ev_target_abort_sig(ev_target_abort_sig), .bridge_is_master(bridge_is_master),
    .parity_response_en(parity_response_en));
  pbw_sec_bus_model i_pbw_sec_bus_model (.run_clk(run_clk), .want_bus(want_bus),
    .raise_serr(raise_serr), .raise_perr(raise_perr), .secondary_clk(secondary_clk),
    .secondary_other_req_n(secondary_other_req_n),
    .secondary_system_error_n(secondary_system_error_n),
    .secondary_parity_error_n(secondary_parity_error_n));

  // 25 MHz clock and a hang guard far beyond the few hundred cycles needed
  always #20 clk = ~clk;
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 5000) begin
      fail_count++;
      report_and_stop();
    end
  end

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checks++;
    if (got !== exp) begin
      fail_count++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic wr(input logic [5:0] dw, input logic [3:0] be, input logic [31:0] d);
    @(negedge clk);
    {cfg_wr, cfg_dword, cfg_be, cfg_wdata} = {1'b1, dw, be, d};
    @(negedge clk);
    cfg_wr = 1'b0;
  endtask
  task automatic rd(input logic [5:0] dw, input logic [31:0] exp);
    @(negedge clk);
    {cfg_rd, cfg_dword} = {1'b1, dw};
    @(negedge clk);
    cfg_rd = 1'b0;
    chk(cfg_rdata, exp);
  endtask

  task automatic t_regs;
    rd(6'h00, 32'h0);
    wr(6'h00, 4'hf, 32'hffff_ffff);
    rd(6'h00, 32'h0);
    rd(PBW_DW_BUSNUM, 32'h0);
    rd(PBW_DW_IOSTAT, 32'h0200_0101);
    rd(PBW_DW_IOUPPER, 32'h0);
    wr(PBW_DW_BUSNUM, 4'hf, 32'h0306_0201);
    rd(PBW_DW_BUSNUM, 32'h0306_0201);
    wr(PBW_DW_IOSTAT, 4'h7, 32'h00ff_5f3e);
    rd(PBW_DW_IOSTAT, 32'h0200_5131);
    wr(PBW_DW_IOUPPER, 4'hf, 32'h0001_0001);
    rd(PBW_DW_IOUPPER, 32'h0001_0001);
    $display("t_regs done");
  endtask
  task automatic t_fwd;
    logic [7:0] bl [5] = '{8'h01, 8'h02, 8'h04, 8'h06, 8'h07};
    logic c;
    for (int i = 0; i < 5; i++) begin
      @(negedge clk);
      {fwd_req, fwd_bus} = {1'b1, bl[i]};
      @(negedge clk);
      fwd_req = 1'b0;
      c = bl[i] >= 8'h02 && bl[i] <= 8'h06;
      chk({fwd_claim, fwd_as_type0, fwd_as_type1}, {c, c & bl[i] == 2, c & bl[i] != 2});
    end
    $display("t_fwd done");
  endtask
  task automatic t_io;
    logic [31:0] al [5] = '{32'h0001_2fff, 32'h0001_3000, 32'h0001_5fff, 32'h0001_6000,
                            32'h0000_4000};
    for (int i = 0; i < 5; i++) begin
      @(negedge clk);
      {io_req, io_addr} = {1'b1, al[i]};
      @(negedge clk);
      io_req = 1'b0;
      chk({io_done, io_forward}, {1'b1, al[i] >= 32'h0001_3000 && al[i] <= 32'h0001_5fff});
    end
    $display("t_io done");
  endtask
  task automatic t_status;
    {parity_response_en, raise_perr} = 2'b11;
    repeat (8) @(negedge clk);
    rd(PBW_DW_IOSTAT, 32'h0200_5131);
    bridge_is_master = 1'b1;
    repeat (8) @(negedge clk);
    {raise_perr, bridge_is_master, raise_serr} = 3'b001;
    {ev_parity_detect, ev_master_abort, ev_target_abort_rcvd, ev_target_abort_sig} = 4'hf;
    @(negedge clk);
    {ev_parity_detect, ev_master_abort, ev_target_abort_rcvd, ev_target_abort_sig} = 4'h0;
    raise_serr = 1'b0;
    repeat (8) @(negedge clk);
    rd(PBW_DW_IOSTAT, 32'hfb00_5131);
    wr(PBW_DW_IOSTAT, 4'h8, 32'h8000_0000);
    rd(PBW_DW_IOSTAT, 32'h7b00_5131);
    wr(PBW_DW_IOSTAT, 4'hc, 32'hf9ff_0000);
    rd(PBW_DW_IOSTAT, 32'h0200_5131);
    $display("t_status done");
  endtask
  task automatic t_lat;
    {run_clk, want_bus} = 2'b11;
    repeat (6) @(negedge clk);
    chk(sec_grant_internal, 1'b0);
    sec_frame_start = 1'b1;
    @(negedge clk);
    sec_frame_start = 1'b0;
    repeat (12) @(negedge clk);
    chk(sec_terminate, 1'b0);
    for (int n = 0; n < 40 && sec_terminate !== 1'b1; n++) @(negedge clk);
    chk(sec_terminate, 1'b1);
    {sec_txn_end, want_bus} = 2'b10;
    @(negedge clk);
    sec_txn_end = 1'b0;
    chk(sec_terminate, 1'b0);
    repeat (6) @(negedge clk);
    chk(sec_grant_internal, 1'b1);
    sec_frame_start = 1'b1;
    @(negedge clk);
    sec_frame_start = 1'b0;
    repeat (40) @(negedge clk);
    chk(sec_terminate, 1'b0);
    want_bus = 1'b1;
    repeat (6) @(negedge clk);
    chk(sec_terminate, 1'b1);
    sec_frame_start = 1'b1;
    @(negedge clk);
    sec_frame_start = 1'b0;
    chk(sec_terminate, 1'b0);
    {sec_txn_end, want_bus} = 2'b10;
    @(negedge clk);
    sec_txn_end = 1'b0;
    run_clk = 1'b0;
    $display("t_lat done");
  endtask

  task automatic report_and_stop;
    $display("checks=%0d fail_count=%0d", checks, fail_count);
    if (fail_count == 0 && checks > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask

  // reset for five cycles, then run the scenarios in turn
  initial begin
    {nrst, cfg_wr, cfg_rd, fwd_req, io_req, sec_frame_start, sec_txn_end} = '0;
    {ev_parity_detect, ev_master_abort, ev_target_abort_rcvd, ev_target_abort_sig} = '0;
    {bridge_is_master, parity_response_en, run_clk, want_bus, raise_serr, raise_perr} = '0;
    {cfg_dword, cfg_be, fwd_bus, cfg_wdata, io_addr} = '0;
    repeat (5) @(negedge clk);
    nrst = 1'b1;
    repeat (6) @(negedge clk);
    t_regs();
    t_fwd();
    t_io();
    t_status();
    t_lat();
    report_and_stop();
  end
endmodule // pbw_bridge_cfg_tb

// File: pbw_pkg.sv
// constants for the bridge bus-number, latency, i/o window and secondary status block
package pbw_pkg;

  // configuration dword indexes (byte offset >> 2)
  localparam logic [5:0] PBW_DW_BUSNUM    = 6'h06;  // 18h..1bh
  localparam logic [5:0] PBW_DW_IOSTAT    = 6'h07;  // 1ch..1fh
  localparam logic [5:0] PBW_DW_IOUPPER   = 6'h0c;  // 30h..33h

  // byte offsets of the registers
  localparam logic [7:0] PBW_OFS_UPSTREAM_BUS   = 8'h18;
  localparam logic [7:0] PBW_OFS_DOWNSTREAM_BUS = 8'h19;
  localparam logic [7:0] PBW_OFS_HIGHEST_BUS    = 8'h1a;
  localparam logic [7:0] PBW_OFS_LATENCY_LIMIT  = 8'h1b;
  localparam logic [7:0] PBW_OFS_IO_BOTTOM      = 8'h1c;
  localparam logic [7:0] PBW_OFS_IO_TOP         = 8'h1d;
  localparam logic [7:0] PBW_OFS_ERROR_FLAGS    = 8'h1e;
  localparam logic [7:0] PBW_OFS_IO_BOTTOM_UP   = 8'h30;
  localparam logic [7:0] PBW_OFS_IO_TOP_UP      = 8'h32;

  // reset values
  localparam logic [7:0]  PBW_RST_BUS      = 8'h00;
  localparam logic [7:0]  PBW_RST_LATENCY  = 8'h00;
  localparam logic [3:0]  PBW_RST_IO_NIB   = 4'h0;
  localparam logic [15:0] PBW_RST_IO_UPPER = 16'h0000;
  localparam logic [15:0] PBW_RST_FLAGS    = 16'h0200;

  // i/o window fixed fields
  localparam logic [3:0]  PBW_IO_CAP_32    = 4'h1;    // low nibble, 32-bit i/o
  localparam logic [11:0] PBW_IO_BOT_FILL  = 12'h000;
  localparam logic [11:0] PBW_IO_TOP_FILL  = 12'hfff;

  // secondary status field positions
  localparam int PBW_ST_PARITY_DET  = 15;
  localparam int PBW_ST_SYSERR_RCV  = 14;
  localparam int PBW_ST_MABORT_RCV  = 13;
  localparam int PBW_ST_TABORT_RCV  = 12;
  localparam int PBW_ST_TABORT_SIG  = 11;
  localparam int PBW_ST_DATA_PERR   = 8;
  localparam logic [15:0] PBW_ST_W1C_MASK = 16'hf900;
  localparam logic [15:0] PBW_ST_FIXED    = 16'h0200;  // devsel timing 01b, medium

  // synchroniser depth
  localparam int PBW_SYNC_STAGES = 2;

  // latency timer states
  typedef enum logic [2:0] {
    PBW_LT_IDLE    = 3'b001,
    PBW_LT_RUN     = 3'b010,
    PBW_LT_EXPIRED = 3'b100
  } pbw_lat_state_t;

endpackage

// File: pbw_sec_bus_model.sv
// secondary bus model: other masters, link clock and error pins
`timescale 1ns/1ns
module pbw_sec_bus_model (
  input  wire logic run_clk,
  input  wire logic want_bus,
  input  wire logic raise_serr,
  input  wire logic raise_perr,
  output logic      secondary_clk,
  output logic      secondary_other_req_n,
  output logic      secondary_system_error_n,
  output logic      secondary_parity_error_n
);
  // link clock stands low while run_clk is low; offset keeps edges off clk
  initial begin
    secondary_clk = 1'b0;
    #13;
    forever begin
      #160;
      secondary_clk = run_clk ? ~secondary_clk : 1'b0;
    end
  end
  assign secondary_other_req_n = ~want_bus;
  // error pins are pulled up, so released reads high
  assign secondary_system_error_n = ~raise_serr;
  assign secondary_parity_error_n = ~raise_perr;
endmodule // pbw_sec_bus_model

// File: pbw_sync.sv
// two-stage synchroniser for a group of asynchronous levels
`timescale 1ns/1ns
module pbw_sync #(
  parameter int WIDTH = 1,
  parameter logic [WIDTH-1:0] RST_VAL = '0
) (
  input  wire logic             clk,
  input  wire logic             rst_n,
  input  wire logic [WIDTH-1:0] async_in,
  output logic      [WIDTH-1:0] sync_out
);
  logic [WIDTH-1:0] meta_ff;

  // first stage feeds only the second stage
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      meta_ff  <= RST_VAL;
      sync_out <= RST_VAL;
    end else begin
      meta_ff  <= async_in;
      sync_out <= meta_ff;
    end
  end
endmodule // pbw_sync
